// *** core/pwm_auto_tune.sv ***
/*
 * Automatic tuning sequencer for a voltage mode PWM chopper, with APB registers.
 * Assumes measured/target current, chop_on, fullstep and amplitude_sum come
 * from pclk logic; step_pin is asynchronous and is synchronised here.
 */
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
module pwm_auto_tune #(
	parameter int STANDSTILL_CYCLES = tune_pkg::STANDSTILL_CYCLES,
	parameter int PHASE1_CYCLES = tune_pkg::PHASE1_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic step_pin,
	input wire logic [4:0] current_scale,
	input wire logic chop_on,
	input wire logic [7:0] measured_current,
	input wire logic [7:0] target_current,
	input wire logic fullstep,
	input wire logic [8:0] amplitude_sum,
	output logic [7:0] offset_result,
	output logic [7:0] gradient_result,
	output logic signed [7:0] amplitude_correction,
	output logic feed_forward_mode,
	output logic standstill
);
	////////////////////////////////////////////////////////////////
	logic step_meta_r, step_sync_r, step_prev_r;
	logic [1:0] ctrl_r;
	logic [4:0] run_current_scale_r;
	logic [2:0] gain_r;
	logic [7:0] offset_initial_value_r;
	logic phase_one_done_r;
	tune_pkg::phase_t phase_r;
	logic [31:0] p1_count_r;
	logic [7:0] offset_work_r;
	logic [2:0] fs_count_r;
	logic chop_prev_r;
	standstill_if sif ();

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_meta_r <= 1'b0;
			step_sync_r <= 1'b0;
			step_prev_r <= 1'b0;
		end else begin
			step_meta_r <= step_pin;
			step_sync_r <= step_meta_r;
			step_prev_r <= step_sync_r;
		end
	end
	assign sif.step_seen = step_sync_r && !step_prev_r;

	standstill_timer #(.CYCLES(STANDSTILL_CYCLES)) u_stst (
		.pclk(pclk),
		.presetn(presetn),
		.tif(sif)
	);

	////////////////////////////////////////////////////////////////
	// APB: no wait states, read data captured in setup
	logic setup, wr_acc;
	logic mapped;
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pready && pwrite;
	assign mapped = paddr == tune_pkg::ADDR_CTRL || paddr == tune_pkg::ADDR_CONFIG ||
		paddr == tune_pkg::ADDR_STATUS || paddr == tune_pkg::ADDR_AMPLITUDE ||
		paddr == tune_pkg::ADDR_INVALIDATE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite) begin
				case (paddr)
					tune_pkg::ADDR_CTRL: prdata <= {30'h0, ctrl_r};
					tune_pkg::ADDR_CONFIG: prdata <= {16'h0, offset_initial_value_r, gain_r, run_current_scale_r};
					tune_pkg::ADDR_STATUS: prdata <= {8'h0, gradient_result, offset_result, 2'h0,
						amplitude_correction == 8'sh0, feed_forward_mode, phase_r, standstill, phase_one_done_r};
					tune_pkg::ADDR_AMPLITUDE: prdata <= {15'h0, amplitude_sum, amplitude_correction};
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	logic wr_ctrl, wr_cfg, wr_inval;
	assign wr_ctrl = wr_acc && paddr == tune_pkg::ADDR_CTRL;
	assign wr_cfg = wr_acc && paddr == tune_pkg::ADDR_CONFIG;
	assign wr_inval = wr_acc && paddr == tune_pkg::ADDR_INVALIDATE && pwdata[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= tune_pkg::CTRL_RESET;
			run_current_scale_r <= tune_pkg::RUN_CURRENT_SCALE_RESET;
			gain_r <= tune_pkg::GAIN_RESET;
			offset_initial_value_r <= tune_pkg::OFS_INIT_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= pwdata[1:0];
			end
			if (wr_cfg) begin
				run_current_scale_r <= pwdata[tune_pkg::CFG_RUN_CURRENT_SCALE_LSB +: 5];
				gain_r <= pwdata[tune_pkg::CFG_GAIN_LSB +: 3];
				offset_initial_value_r <= pwdata[tune_pkg::CFG_OFS_LSB +: 8];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	logic auto_amp, auto_full, chop_edge, regulate;
	logic signed [8:0] cur_err;
	logic signed [12:0] corr_sum;
	assign auto_amp = ctrl_r[tune_pkg::CTRL_AUTO_AMP_BIT];
	assign auto_full = auto_amp && ctrl_r[tune_pkg::CTRL_AUTO_GRAD_BIT];
	assign chop_edge = chop_on && !chop_prev_r;
	assign regulate = auto_amp && chop_edge;
	assign cur_err = $signed({1'b0, target_current}) - $signed({1'b0, measured_current});
	// Product widened before multiplying so a large error times gain 7 cannot wrap
	assign corr_sum = 13'(amplitude_correction) + ((13'(cur_err) * 13'($signed({1'b0, gain_r}))) >>> 3);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chop_prev_r <= 1'b0;
			standstill <= 1'b0;
			feed_forward_mode <= 1'b0;
		end else begin
			chop_prev_r <= chop_on;
			standstill <= sif.standstill;
			feed_forward_mode <= !auto_amp;
		end
	end

	// Integrating current regulator, measured once per chopper on phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			amplitude_correction <= 8'sh0;
		end else if (!auto_amp) begin
			amplitude_correction <= 8'sh0;
		end else if (regulate) begin
			if (corr_sum > 13'sd127) begin
				amplitude_correction <= 8'sh7F;
			end else if (corr_sum < -13'sd128) begin
				amplitude_correction <= 8'sh80;
			end else begin
				amplitude_correction <= corr_sum[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	logic p1_cond, p2_cond, in_window;
	logic [13:0] ofs_run_current_scale;
	logic [15:0] sum_x64, sum_x8, ofs_x3;
	assign ofs_run_current_scale = 14'(offset_result) * 14'({1'b0, run_current_scale_r} + 6'h1);
	assign sum_x64 = {1'b0, amplitude_sum, 6'h0};
	assign sum_x8 = {4'h0, amplitude_sum, 3'h0};
	assign ofs_x3 = 16'(ofs_run_current_scale) * 16'h3;
	// 1.5*k/32 < sum < 4*k/32 rewritten without division
	assign in_window = sum_x64 > ofs_x3 && sum_x8 < {2'h0, ofs_run_current_scale} &&
		amplitude_sum < tune_pkg::SUM_LIMIT;
	assign p1_cond = auto_full && standstill && current_scale == run_current_scale_r;
	assign p2_cond = auto_full && phase_one_done_r && !standstill;

	// Leaving conditions aborts the attempt; it restarts when they recur
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r <= tune_pkg::PH_IDLE;
		end else begin
			case (phase_r)
				tune_pkg::PH_IDLE: begin
					if (p1_cond) begin
						phase_r <= tune_pkg::PH_ONE;
					end else if (p2_cond) begin
						phase_r <= tune_pkg::PH_TWO;
					end
				end
				tune_pkg::PH_ONE: begin
					if (!p1_cond || p1_count_r >= 32'(PHASE1_CYCLES - 1)) begin
						phase_r <= tune_pkg::PH_IDLE;
					end
				end
				tune_pkg::PH_TWO: begin
					if (!p2_cond || wr_inval) begin
						phase_r <= tune_pkg::PH_IDLE;
					end
				end
				default: phase_r <= tune_pkg::PH_IDLE;
			endcase
		end
	end

	// Phase one: offset steps toward the target current, bounded duration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p1_count_r <= 32'h0;
			offset_work_r <= tune_pkg::OFS_INIT_RESET;
		end else if (phase_r != tune_pkg::PH_ONE) begin
			p1_count_r <= 32'h0;
			offset_work_r <= phase_one_done_r ? offset_result : offset_initial_value_r;
		end else begin
			p1_count_r <= p1_count_r + 32'h1;
			if (chop_edge && cur_err > 9'sd0 && offset_work_r != 8'hFF) begin
				offset_work_r <= offset_work_r + 8'h1;
			end else if (chop_edge && cur_err < 9'sd0 && offset_work_r != 8'h0) begin
				offset_work_r <= offset_work_r - 8'h1;
			end
		end
	end

	logic p1_finish;
	assign p1_finish = phase_r == tune_pkg::PH_ONE && p1_cond && p1_count_r >= 32'(PHASE1_CYCLES - 1);

	// Invalidate clears completion; a finish in the same cycle still wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_one_done_r <= 1'b0;
			offset_result <= tune_pkg::OFS_INIT_RESET;
		end else if (p1_finish) begin
			phase_one_done_r <= 1'b1;
			offset_result <= offset_work_r;
		end else if (wr_inval) begin
			phase_one_done_r <= 1'b0;
		end
	end

	// Phase two: one gradient count per 8 fullsteps inside the window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fs_count_r <= 3'h0;
			gradient_result <= tune_pkg::GRAD_RESET;
		end else if (wr_cfg && pwdata[tune_pkg::CFG_GRAD_LOAD_BIT]) begin
			gradient_result <= pwdata[tune_pkg::CFG_GRAD_LSB +: 8];
			fs_count_r <= 3'h0;
		end else if (phase_r == tune_pkg::PH_TWO && p2_cond && in_window && fullstep) begin
			fs_count_r <= fs_count_r + 3'h1;
			if (fs_count_r == tune_pkg::FULLSTEPS_PER_GRAD) begin
				// Correction sign shows which way the gradient falls short
				if (amplitude_correction > 8'sh0 && gradient_result != 8'hFF) begin
					gradient_result <= gradient_result + 8'h1;
				end else if (amplitude_correction < 8'sh0 && gradient_result != 8'h0) begin
					gradient_result <= gradient_result - 8'h1;
				end
			end
		end
	end
endmodule

// *** common/tune_pkg.sv ***
/*
 * Constants for the voltage PWM auto tuning sequencer: register map,
 * field positions, reset values and cycle counts.
 * Assumes a 32-bit APB register bus and a 250 MHz pclk.
 */
package tune_pkg;

	////////////////////////////////////////////////////////////////
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_AMPLITUDE = 8'h0C;
	localparam logic [7:0] ADDR_INVALIDATE = 8'h10;

	// CTRL fields
	localparam int CTRL_AUTO_AMP_BIT = 0;
	localparam int CTRL_AUTO_GRAD_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h3;

	// CONFIG fields
	localparam int CFG_RUN_CURRENT_SCALE_LSB = 0;
	localparam int CFG_GAIN_LSB = 5;
	localparam int CFG_OFS_LSB = 8;
	localparam int CFG_GRAD_LSB = 16;
	localparam int CFG_GRAD_LOAD_BIT = 24;
	localparam logic [4:0] RUN_CURRENT_SCALE_RESET = 5'h1F;
	localparam logic [2:0] GAIN_RESET = 3'h1;
	localparam logic [7:0] OFS_INIT_RESET = 8'h24;
	localparam logic [7:0] GRAD_RESET = 8'h0E;

	// STATUS fields
	localparam int ST_DONE_BIT = 0;
	localparam int ST_STST_BIT = 1;
	localparam int ST_PHASE_LSB = 2;
	localparam int ST_FF_BIT = 4;
	localparam int ST_CORR_ZERO_BIT = 5;
	localparam int ST_OFS_LSB = 8;
	localparam int ST_GRAD_LSB = 16;

	////////////////////////////////////////////////////////////////
	localparam int STANDSTILL_CYCLES = 1048576;
	localparam int PHASE1_CYCLES = 1572864;
	localparam logic [2:0] FULLSTEPS_PER_GRAD = 3'h7;
	localparam logic [8:0] SUM_LIMIT = 9'h0FF;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_ONE = 2'b01,
		PH_TWO = 2'b10
	} phase_t;

endpackage

// *** common/standstill_if.sv ***
/*
 * Carrier between the sequencer and its standstill timer.
 * Assumes step_seen is already synchronous to pclk.
 */
`timescale 1ns/1ps
interface standstill_if;
	logic step_seen;
	logic standstill;

	modport timer (input step_seen, output standstill);
	modport user (output step_seen, input standstill);
endinterface

// *** core/standstill_timer.sv ***
/*
 * Standstill timer: flags standstill a fixed count after the last step.
 * Assumes step_seen is a one-cycle pulse on pclk.
 */
`timescale 1ns/1ps
module standstill_timer #(
	parameter int CYCLES = tune_pkg::STANDSTILL_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	standstill_if.timer tif
);
	logic [31:0] count_r;

	// Counter saturates so standstill stays up indefinitely
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= 32'h0;
		end else if (tif.step_seen) begin
			count_r <= 32'h0;
		end else if (count_r < 32'(CYCLES)) begin
			count_r <= count_r + 32'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tif.standstill <= 1'b0;
		end else begin
			tif.standstill <= !tif.step_seen && (count_r >= 32'(CYCLES - 1));
		end
	end
endmodule

// *** verification/pwm_auto_tune_asserts.sv ***
/* Port checker for pwm_auto_tune.
   Assumes a bind onto its top ports and one pclk domain. */
`timescale 1ns/1ps
module pwm_auto_tune_asserts #(
	parameter int STANDSTILL_CYCLES = 64
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic step_pin,
	input wire logic [7:0] offset_result,
	input wire logic [7:0] gradient_result,
	input wire logic feed_forward_mode,
	input wire logic standstill
);
	int quiet_cnt;
	wire logic acc = psel && penable && pready && pwrite;
	wire logic wr_ctrl = acc && paddr == tune_pkg::ADDR_CTRL;
	wire logic cfg_ld = acc && paddr == tune_pkg::ADDR_CONFIG && pwdata[24];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// Cycles since the last step edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_cnt <= 0;
		end else if ($rose(step_pin)) begin
			quiet_cnt <= 0;
		end else begin
			quiet_cnt <= quiet_cnt + 1;
		end
	end
	sequence answer_s;
		pready ##1 !pready;
	endsequence
	////////////////////////////////////////////////////////////////
	setup_answer_a: assert property (psel && !penable |=> answer_s)
		else $error("APB answer timing wrong");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	ff_follow_a: assert property (wr_ctrl |-> ##2 feed_forward_mode == !$past(pwdata[0], 2))
		else $error("feed forward mode wrong");
	stst_drop_a: assert property ($rose(step_pin) |-> ##[1:6] !standstill)
		else $error("standstill kept after step");
	stst_early_a: assert property (quiet_cnt > 5 && quiet_cnt < STANDSTILL_CYCLES |-> !standstill)
		else $error("standstill too early");
	stst_late_a: assert property (quiet_cnt == STANDSTILL_CYCLES + 8 |-> standstill)
		else $error("standstill too late");
	grad_unit_a: assert property ($changed(gradient_result) |-> $past(cfg_ld) || $past(cfg_ld, 2) ||
		8'(gradient_result - $past(gradient_result)) inside {8'h01, 8'hFF})
		else $error("gradient jumped");
	ofs_capture_a: assert property ($changed(offset_result) |-> $past(standstill))
		else $error("offset captured while moving");
endmodule

// *** verification/motion_ctrl.sv ***
/* Motion controller model: step pulses with a fullstep strobe each.
   Assumes the bench calls move() and owns pclk. */
`timescale 1ns/1ps
module motion_ctrl (
	input wire logic pclk,
	output logic step_pin,
	output logic fullstep
);
	initial begin
		step_pin = 1'h0;
		fullstep = 1'h0;
	end
	// Slow single steps come from a long gap
	task automatic move(input int steps, input int gap);
		int g;
		for (int i = 0; i < steps; i++) begin
			// Last steps stretch out, never a hard stop
			g = gap + (i > steps - 4 ? 4 * (i - steps + 4) : 0);
			@(posedge pclk);
			step_pin <= 1'h1;
			repeat (2) @(posedge pclk);
			step_pin <= 1'h0;
			repeat (g / 2 - 2) @(posedge pclk);
			fullstep <= 1'h1;
			@(posedge pclk);
			fullstep <= 1'h0;
			repeat (g / 2 - 2) @(posedge pclk);
		end
	endtask
endmodule

// *** verification/voltage_pwm_auto_tuning_tb.sv ***
/* Self-checking bench for pwm_auto_tune with an APB master.
   Assumes short counts: standstill 64, phase one 100. */
`timescale 1ns/1ps
module voltage_pwm_auto_tuning_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic step_pin, chop_on, fullstep, feed_forward_mode, standstill;
	logic [7:0] paddr, measured_current, target_current, offset_result, gradient_result;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] current_scale;
	logic [8:0] amplitude_sum;
	logic signed [7:0] amplitude_correction;
	int err_total, comparisons, run_current_scale, ofs, exp_grad, n;
	pwm_auto_tune #(.STANDSTILL_CYCLES(64), .PHASE1_CYCLES(100)) i_pwm_auto_tune (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .step_pin, .current_scale, .chop_on,
		.measured_current, .target_current, .fullstep, .amplitude_sum, .offset_result, .gradient_result,
		.amplitude_correction, .feed_forward_mode, .standstill);
	motion_ctrl i_motion_ctrl (.pclk, .step_pin, .fullstep);
	initial begin
		pclk = 1'h0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) chop_on <= ~chop_on;
	////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0s exp %0h got %0h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (k >= 50) begin
			err_total++;
			print_verdict;
		end
	endtask
	task automatic poll_done;
		n = 0;
		do begin
			apb(1'h0, tune_pkg::ADDR_STATUS, 32'h0);
			n++;
		end while (rd[0] !== 1'h1 && n < 200);
		if (n >= 200) begin
			err_total++;
			print_verdict;
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		chop_on = 1'h0;
		current_scale = 5'h00;
		measured_current = 8'h00;
		target_current = 8'hC0;
		amplitude_sum = 9'h000;
		err_total = 0;
		comparisons = 0;
		void'($urandom(32'hE04106B4));
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, tune_pkg::ADDR_CTRL, 32'h0);
		chk("ctrl", 32'(tune_pkg::CTRL_RESET), rd);
		apb(1'h0, tune_pkg::ADDR_CONFIG, 32'h0);
		chk("config", {16'h0, tune_pkg::OFS_INIT_RESET, tune_pkg::GAIN_RESET, tune_pkg::RUN_CURRENT_SCALE_RESET}, rd);
		apb(1'h0, 8'h14, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, er});
		chk("unmapped_data", 32'h0, rd);
		chk("grad_reset", 32'(tune_pkg::GRAD_RESET), {24'h0, gradient_result});
		for (int c = 0; c < 4; c++) begin
			apb(1'h1, tune_pkg::ADDR_CTRL, c);
			repeat (3) @(posedge pclk);
			chk("ff_mode", {31'h0, ~c[0]}, {31'h0, feed_forward_mode});
			if (!c[0]) begin
				chk("corr_off", 32'h0, {24'h0, amplitude_correction});
			end
		end
		$display("register test done");
		run_current_scale = $urandom % 8;
		apb(1'h1, tune_pkg::ADDR_CONFIG, run_current_scale + 32'h2420);
		current_scale <= 5'(run_current_scale + 8);
		measured_current <= 8'($urandom % 64);
		repeat (250) @(posedge pclk);
		apb(1'h0, tune_pkg::ADDR_STATUS, 32'h0);
		chk("done_blocked", 32'h0, {31'h0, rd[0]});
		// Measured current stays below target, so the regulator pushes up to its ceiling
		chk("corr_sat", 32'h7F, {24'h0, amplitude_correction});
		apb(1'h0, tune_pkg::ADDR_AMPLITUDE, 32'h0);
		chk("amplitude", 32'h7F, rd);
		current_scale <= 5'(run_current_scale);
		i_motion_ctrl.move(1, 16);
		poll_done;
		ofs = offset_result;
		current_scale <= 5'(run_current_scale + 8);
		chk("ofs_learn", 32'h1, 32'(ofs > 36));
		$display("phase one test done");
		exp_grad = 14;
		amplitude_sum <= 9'h0FF;
		i_motion_ctrl.move(8, 16);
		chk("grad_out", exp_grad, {24'h0, gradient_result});
		amplitude_sum <= 9'(ofs * (run_current_scale + 1) * 11 / 128);
		i_motion_ctrl.move(16, 16);
		exp_grad += 2;
		chk("grad_in", exp_grad, {24'h0, gradient_result});
		apb(1'h1, tune_pkg::ADDR_INVALIDATE, 32'h1);
		i_motion_ctrl.move(8, 16);
		chk("grad_gate", exp_grad, {24'h0, gradient_result});
		$display("phase two test done");
		current_scale <= 5'(run_current_scale);
		poll_done;
		exp_grad = $urandom % 256;
		apb(1'h1, tune_pkg::ADDR_CONFIG, 32'h01000000 | exp_grad << 16 | run_current_scale + 32'h2420);
		@(posedge pclk);
		chk("grad_load", exp_grad, {24'h0, gradient_result});
		$display("rerun and preload test done");
		print_verdict;
	end
endmodule
bind pwm_auto_tune pwm_auto_tune_asserts #(.STANDSTILL_CYCLES(STANDSTILL_CYCLES)) i_asserts (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .step_pin, .offset_result, .gradient_result,
	.feed_forward_mode, .standstill);
